// File: pkg/rag_pkg.sv
// constants, types and field layout of the region access guard
package rag_pkg;
    localparam int          RAG_NREG        = 8;
    localparam logic [31:0] RAG_OFS_INFO    = 32'he000ed90;
    localparam logic [31:0] RAG_OFS_CTRL    = 32'he000ed94;
    localparam logic [31:0] RAG_OFS_SEL     = 32'he000ed98;
    localparam logic [31:0] RAG_OFS_BASE    = 32'he000ed9c;
    localparam logic [31:0] RAG_OFS_ATTR    = 32'he000eda0;
    localparam logic        RAG_IMPLEMENTED = 1'b1;
    localparam logic [7:0]  RAG_DREG_CNT    = 8'h08;
    localparam int          RAG_DREG_LO     = 8;
    localparam int          RAG_CTL_EN      = 0;
    localparam int          RAG_CTL_HFN     = 1;
    localparam int          RAG_CTL_PDEF    = 2;
    localparam logic [2:0]  RAG_CTL_RST     = 3'h0;
    localparam logic [7:0]  RAG_SEL_RST     = 8'h00;
    localparam int          RAG_BASE_VALID  = 4;
    localparam logic [31:0] RAG_BASE_MASK   = 32'hffffffe0;
    localparam logic [31:0] RAG_ATTR_MASK   = 32'h173fff3f;
    localparam logic [31:0] RAG_ATTR_RST    = 32'h00000000;
    localparam logic [31:0] RAG_BASE_RST    = 32'h00000000;
    localparam int          RAG_XN          = 28;
    localparam int          RAG_AP_LO       = 24;
    localparam int          RAG_S           = 18;
    localparam int          RAG_C           = 17;
    localparam int          RAG_B           = 16;
    localparam int          RAG_SRD_LO      = 8;
    localparam int          RAG_SIZE_LO     = 1;
    localparam int          RAG_EN          = 0;
    localparam logic [19:0] RAG_SCS_TAG     = 20'he000e;
    localparam logic [31:0] RAG_VEC_TOP     = 32'h000000c0;
    typedef struct packed {
        logic xn;
        logic c;
        logic b;
        logic s;
    } rag_attr_s;
endpackage

// File: pkg/rag_cfg_if.sv
// region table carrier between control, storage and address match
`timescale 1ns/100ps
`default_nettype none
interface rag_cfg_if;
    logic        wr_en;
    logic        wr_attr;
    logic [2:0]  wr_idx;
    logic [31:0] wr_data;
    logic [2:0]  rd_idx;
    logic [31:0] rd_base;
    logic [31:0] rd_attr;
    logic [31:0] ent_base [8];
    logic [31:0] ent_attr [8];
    modport ctl   (output wr_en, wr_attr, wr_idx, wr_data, rd_idx,
                   input rd_base, rd_attr, ent_base, ent_attr);
    modport mem   (input wr_en, wr_attr, wr_idx, wr_data, rd_idx,
                   output rd_base, rd_attr, ent_base, ent_attr);
    modport match (input ent_base, ent_attr);
endinterface
`default_nettype wire

// File: hdl/rag_region_mem.sv
// storage for the eight region base and attribute words
`timescale 1ns/100ps
`default_nettype none
module rag_region_mem
    import rag_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // table port
    rag_cfg_if.mem    cfg
);
    genvar g;
    generate
        for (g = 0; g < RAG_NREG; g++) begin : g_ent
            logic [31:0] base_r;
            logic [31:0] attr_r;
            wire hit = cfg.wr_en && (cfg.wr_idx == 3'(g));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    base_r <= RAG_BASE_RST;
                    attr_r <= RAG_ATTR_RST;
                end else if (hit && cfg.wr_attr) begin
                    attr_r <= cfg.wr_data & RAG_ATTR_MASK;
                end else if (hit) begin
                    base_r <= cfg.wr_data & RAG_BASE_MASK;
                end
            end
            assign cfg.ent_base[g] = base_r;
            assign cfg.ent_attr[g] = attr_r;
        end
    endgenerate

    // read words come from a register, one cycle behind the index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.rd_base <= RAG_BASE_RST;
            cfg.rd_attr <= RAG_ATTR_RST;
        end else begin
            cfg.rd_base <= cfg.ent_base[cfg.rd_idx];
            cfg.rd_attr <= cfg.ent_attr[cfg.rd_idx];
        end
    end
endmodule // rag_region_mem
`default_nettype wire

// File: hdl/rag_region_match.sv
// per-region address compare with subregion disable
`timescale 1ns/100ps
`default_nettype none
module rag_region_match
    import rag_pkg::*;
(
    // region table
    rag_cfg_if.match   cfg,
    // access address and per-region hits
    input  wire logic [31:0] addr,
    output logic [7:0]       hit
);
    genvar g;
    generate
        for (g = 0; g < RAG_NREG; g++) begin : g_cmp
            wire [31:0] a    = cfg.ent_attr[g];
            wire [4:0]  size = a[RAG_SIZE_LO +: 5];
            wire [5:0]  n    = {1'b0, size} + 6'h01;
            // a full-map region has no address bits to compare
            wire [31:0] mask = (n == 6'd32) ? 32'h0 : (32'hffffffff << n);
            wire        in_r = ((addr ^ cfg.ent_base[g]) & mask) == 32'h0;
            // subregions only exist from 256B regions upward
            wire [5:0]  sh   = n - 6'h03;
            wire [31:0] subw = addr >> sh;
            wire [2:0]  sub  = subw[2:0];
            wire        off  = (size >= 5'h07) && a[RAG_SRD_LO + sub];
            assign hit[g] = a[RAG_EN] && in_r && !off;
        end
    endgenerate
endmodule // rag_region_match
`default_nettype wire

// File: hdl/rag_top.sv
// region access guard: register file, access check and attribute export
`timescale 1ns/100ps
`default_nettype none
module rag_top
    import rag_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // core access request
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic        acc_fetch,
    input  wire logic        acc_priv,
    input  wire logic        acc_high_pri,
    // check result, one cycle after the request
    output logic             chk_valid,
    output logic             severe_fault_req,
    output logic             chk_execute_never,
    output logic             chk_cacheable,
    output logic             chk_bufferable,
    output logic             chk_shareable,
    output logic             chk_strongly_ordered,
    output logic             chk_region_hit,
    output logic [2:0]       chk_region_num
);
    rag_cfg_if cfg ();

    // apb decode
    wire access  = psel && penable;
    wire sel_inf = paddr == RAG_OFS_INFO;
    wire sel_ctl = paddr == RAG_OFS_CTRL;
    wire sel_rnr = paddr == RAG_OFS_SEL;
    wire sel_bas = paddr == RAG_OFS_BASE;
    wire sel_att = paddr == RAG_OFS_ATTR;
    wire mapped  = sel_inf | sel_ctl | sel_rnr | sel_bas | sel_att;
    // writes land only at the completing edge
    wire wr      = access && pready && pwrite && mapped;
    wire wr_ctl  = wr && sel_ctl;
    wire wr_rnr  = wr && sel_rnr;
    wire wr_bas  = wr && sel_bas;
    wire wr_att  = wr && sel_att;
    wire bas_vld = pwdata[RAG_BASE_VALID];

    logic [2:0]  ctrl_r;
    logic [7:0]  select_r;
    logic [7:0]  select_nxt;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    // select loads from a valid base write too
    assign select_nxt = wr_rnr ? pwdata[7:0] :
                        (wr_bas && bas_vld) ? {4'h0, pwdata[3:0]} :
                        select_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= RAG_CTL_RST;
            select_r <= RAG_SEL_RST;
        end else begin
            if (wr_ctl) begin
                ctrl_r <= pwdata[2:0];
            end
            select_r <= select_nxt;
        end
    end

    // region table port: only values 0-7 are meaningful in select
    assign cfg.wr_en   = wr_bas || wr_att;
    assign cfg.wr_attr = wr_att;
    assign cfg.wr_idx  = (wr_bas && bas_vld) ? pwdata[2:0] : select_r[2:0];
    assign cfg.wr_data = pwdata;
    assign cfg.rd_idx  = select_r[2:0];

    rag_region_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg.mem)
    );

    // read words
    wire [7:0]  dreg     = RAG_IMPLEMENTED ? RAG_DREG_CNT : 8'h00;
    // instruction count and separate flag stay zero
    wire [31:0] info_w   = 32'(dreg) << RAG_DREG_LO;
    wire [31:0] ctrl_w   = {29'h0, ctrl_r};
    wire [31:0] sel_w    = {24'h0, select_r};
    // valid flag reads zero, region field shows the select
    wire [31:0] base_w   = {cfg.rd_base[31:5], 1'b0, select_r[3:0]};
    wire [31:0] rd_w     = sel_inf ? info_w :
                           sel_ctl ? ctrl_w :
                           sel_rnr ? sel_w :
                           sel_bas ? base_w :
                           sel_att ? cfg.rd_attr : 32'h0;

    // one wait state so the registered table read has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= access && !pready_r;
            pslverr_r <= access && !pready_r && !mapped;
            prdata_r  <= (access && !pready_r && !pwrite) ? rd_w : 32'h0;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // access check
    logic [7:0] hit;

    rag_region_match u_match (
        .cfg  (cfg.match),
        .addr (acc_addr),
        .hit  (hit)
    );

    // highest numbered hit wins
    logic       any_hit;
    logic [2:0] win;
    always_comb begin
        any_hit = 1'b0;
        win     = 3'h0;
        for (int i = 0; i < RAG_NREG; i++) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                win     = 3'(i);
            end
        end
    end

    wire [31:0] wattr = cfg.ent_attr[win];
    wire [2:0]  ap    = wattr[RAG_AP_LO +: 3];
    wire        r_xn  = wattr[RAG_XN];
    wire        r_c   = wattr[RAG_C];
    wire        r_b   = wattr[RAG_B];
    wire        r_s   = wattr[RAG_S];

    // permission table for the access-permission field
    logic perm_ok;
    always_comb begin
        unique case (ap)
            3'b000:  perm_ok = 1'b0;
            3'b001:  perm_ok = acc_priv;
            3'b010:  perm_ok = acc_priv || !acc_write;
            3'b011:  perm_ok = 1'b1;
            3'b101:  perm_ok = acc_priv && !acc_write;
            3'b110:  perm_ok = !acc_write;
            3'b111:  perm_ok = !acc_write;
            default: perm_ok = 1'b0;
        endcase
    end

    // default map attributes by address band
    wire        is_scs = acc_addr[31:12] == RAG_SCS_TAG;
    wire        is_vec = acc_addr < RAG_VEC_TOP;
    rag_attr_s  dflt;
    always_comb begin
        unique case (acc_addr[31:29])
            3'h0:    dflt = '{xn: 1'b0, c: 1'b1, b: 1'b0, s: 1'b0};
            3'h1:    dflt = '{xn: 1'b0, c: 1'b1, b: 1'b1, s: 1'b0};
            3'h2:    dflt = '{xn: 1'b1, c: 1'b0, b: 1'b1, s: 1'b0};
            3'h3:    dflt = '{xn: 1'b0, c: 1'b1, b: 1'b1, s: 1'b0};
            3'h4:    dflt = '{xn: 1'b0, c: 1'b1, b: 1'b0, s: 1'b0};
            3'h5:    dflt = '{xn: 1'b1, c: 1'b0, b: 1'b1, s: 1'b1};
            3'h6:    dflt = '{xn: 1'b1, c: 1'b0, b: 1'b1, s: 1'b0};
            default: dflt = '{xn: 1'b1, c: 1'b0, b: 1'b0, s: 1'b1};
        endcase
        if (is_scs) begin
            dflt = '{xn: 1'b1, c: 1'b0, b: 1'b0, s: 1'b1};
        end
    end

    wire en_bit   = ctrl_r[RAG_CTL_EN];
    wire hfn_bit  = ctrl_r[RAG_CTL_HFN];
    wire pdef_bit = ctrl_r[RAG_CTL_PDEF];
    // handler-enable set with global enable clear is left to software
    wire active   = en_bit && !(acc_high_pri && !hfn_bit);

    rag_attr_s attr;
    logic      fault;
    logic      use_reg;
    always_comb begin
        attr    = dflt;
        fault   = 1'b0;
        use_reg = 1'b0;
        if (!active) begin
            // default map only; background bit ignored here
            fault = acc_fetch && dflt.xn;
        end else if (is_scs || is_vec) begin
            fault = acc_fetch && is_scs;
        end else if (any_hit) begin
            use_reg = 1'b1;
            attr    = '{xn: r_xn, c: r_c, b: r_b, s: r_s || (!r_c && !r_b)};
            fault   = !perm_ok || (acc_fetch && r_xn);
        end else if (pdef_bit && acc_priv) begin
            fault = acc_fetch && dflt.xn;
        end else begin
            fault = 1'b1;
        end
    end

    // results held in flops so the core sees clean levels
    logic       vld_r;
    logic       flt_r;
    rag_attr_s  attr_r;
    logic       so_r;
    logic       rh_r;
    logic [2:0] rn_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vld_r  <= 1'b0;
            flt_r  <= 1'b0;
            attr_r <= '0;
            so_r   <= 1'b0;
            rh_r   <= 1'b0;
            rn_r   <= 3'h0;
        end else begin
            vld_r  <= acc_valid;
            flt_r  <= acc_valid && fault;
            attr_r <= acc_valid ? attr : '0;
            so_r   <= acc_valid && !attr.c && !attr.b;
            rh_r   <= acc_valid && use_reg;
            rn_r   <= (acc_valid && use_reg) ? win : 3'h0;
        end
    end

    assign chk_valid            = vld_r;
    assign severe_fault_req     = flt_r;
    assign chk_execute_never    = attr_r.xn;
    assign chk_cacheable        = attr_r.c;
    assign chk_bufferable       = attr_r.b;
    assign chk_shareable        = attr_r.s;
    assign chk_strongly_ordered = so_r;
    assign chk_region_hit       = rh_r;
    assign chk_region_num       = rn_r;
endmodule // rag_top
`default_nettype wire

// File: verif/rag_top_sva.sv
// port assertions and covers for the region access guard
`timescale 1ns/100ps
`default_nettype none
module rag_top_sva
    import rag_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // core access request
    input wire logic        acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic        acc_write,
    input wire logic        acc_fetch,
    input wire logic        acc_priv,
    input wire logic        acc_high_pri,
    // check result
    input wire logic        chk_valid,
    input wire logic        severe_fault_req,
    input wire logic        chk_execute_never,
    input wire logic        chk_cacheable,
    input wire logic        chk_bufferable,
    input wire logic        chk_shareable,
    input wire logic        chk_strongly_ordered,
    input wire logic        chk_region_hit,
    input wire logic [2:0]  chk_region_num
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = pready && psel && !pwrite;

    AST_CHK_LAT: assert property (acc_valid |=> chk_valid)
        else $error("check result missing one cycle after access");
    AST_CHK_IDLE: assert property (!acc_valid |=> !chk_valid && !severe_fault_req)
        else $error("result or fault without access");
    AST_SCS_ATTR: assert property (acc_valid && acc_addr[31:12] == RAG_SCS_TAG
        |=> chk_execute_never && chk_strongly_ordered && chk_shareable)
        else $error("system space lost execute-never or ordering");
    AST_VEC_OK: assert property (acc_valid && acc_addr < RAG_VEC_TOP |=> !severe_fault_req)
        else $error("vector table access faulted");
    AST_SO_SHARED: assert property (chk_strongly_ordered
        |-> chk_shareable && !chk_cacheable && !chk_bufferable)
        else $error("strongly ordered result not shared");
    AST_APB_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    AST_INFO_RD: assert property (rd_done && paddr == RAG_OFS_INFO
        |-> prdata == 32'h00000800 && !pslverr)
        else $error("info register content wrong");
    AST_CTRL_RD: assert property (rd_done && paddr == RAG_OFS_CTRL |-> prdata[31:3] == 29'h0)
        else $error("control upper bits not zero");
    AST_SEL_RD: assert property (rd_done && paddr == RAG_OFS_SEL |-> prdata[31:8] == 24'h0)
        else $error("select upper bits not zero");
    AST_BASE_RD: assert property (rd_done && paddr == RAG_OFS_BASE |-> !prdata[4])
        else $error("base valid flag read back set");
    AST_NUM_MISS: assert property (chk_valid && !chk_region_hit |-> chk_region_num == 3'h0)
        else $error("region number given on a miss");

    cover property (severe_fault_req);
    cover property (chk_region_hit && chk_region_num == 3'h6);
    cover property (pready && pslverr);
endmodule // rag_top_sva

bind rag_top rag_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_fetch(acc_fetch), .acc_priv(acc_priv), .acc_high_pri(acc_high_pri),
    .chk_valid(chk_valid), .severe_fault_req(severe_fault_req),
    .chk_execute_never(chk_execute_never), .chk_cacheable(chk_cacheable),
    .chk_bufferable(chk_bufferable), .chk_shareable(chk_shareable),
    .chk_strongly_ordered(chk_strongly_ordered), .chk_region_hit(chk_region_hit),
    .chk_region_num(chk_region_num));
`default_nettype wire

// File: verif/rag_core_model.sv
// core side model: presents one access per request to the guard
`timescale 1ns/100ps
`default_nettype none
module rag_core_model (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // request from the bench, kind is {write, fetch, priv, high_pri}
    input wire logic        req,
    input wire logic [31:0] req_addr,
    input wire logic [3:0]  req_kind,
    // access toward the guard
    output logic            acc_valid,
    output logic [31:0]     acc_addr,
    output logic [3:0]      acc_kind
);
    // idle cycles show a toggling address so a stale one never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_valid <= 1'b0;
            acc_addr  <= 32'h0;
            acc_kind  <= 4'h0;
        end else if (req) begin
            acc_valid <= 1'b1;
            acc_addr  <= req_addr;
            acc_kind  <= req_kind;
        end else begin
            acc_valid <= 1'b0;
            acc_addr  <= ~acc_addr;
            acc_kind  <= ~acc_kind;
        end
    end
endmodule // rag_core_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the region access guard
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rag_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, req;
    logic [31:0] paddr, pwdata, prdata, req_addr, acc_addr;
    logic [3:0]  req_kind, acc_kind;
    logic        acc_valid, chk_valid, flt, xn, c, b, s, so, hit;
    logic [2:0]  num;
    int          n_mismatch = 0;
    int          num_checks = 0;
    localparam logic [3:0] K_U = 4'h0, K_P = 4'h2, K_F = 4'h4, K_H = 4'h1;

    rag_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_kind[3]), .acc_fetch(acc_kind[2]), .acc_priv(acc_kind[1]),
        .acc_high_pri(acc_kind[0]), .chk_valid(chk_valid), .severe_fault_req(flt),
        .chk_execute_never(xn), .chk_cacheable(c), .chk_bufferable(b), .chk_shareable(s),
        .chk_strongly_ordered(so), .chk_region_hit(hit), .chk_region_num(num));
    rag_core_model core (.pclk(pclk), .presetn(presetn), .req(req), .req_addr(req_addr),
        .req_kind(req_kind), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind));

    always #2.5 pclk = ~pclk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_acc(input logic [9:0] got, input logic [9:0] exp, input logic [9:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask

    // request held until pready is seen high at a rising edge; answer taken at that edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk_reg({e, q[30:0]} ^ {q[31], 31'h0}, exp);
    endtask

    task automatic acc_chk(input logic [31:0] a, input logic [3:0] k,
                           input logic [9:0] exp, input logic [9:0] m);
        @(posedge pclk);
        req      <= 1'b1;
        req_addr <= a;
        req_kind <= k;
        @(posedge pclk);
        req <= 1'b0;
        do @(negedge pclk); while (chk_valid !== 1'b1);
        chk_acc({flt, xn, c, b, s, so, hit, num}, exp, m);
    endtask

    task automatic s_reset_and_info;
        rd_chk(RAG_OFS_CTRL, 32'h0);
        rd_chk(RAG_OFS_ATTR, 32'h0);
        rd_chk(RAG_OFS_INFO, 32'h00000800);
        wr(RAG_OFS_INFO, 32'hffffffff);
        rd_chk(RAG_OFS_INFO, 32'h00000800);
        rd_chk(32'he000eda4, 32'h80000000);
        wr(RAG_OFS_CTRL, 32'hfffffff8);
        rd_chk(RAG_OFS_CTRL, 32'h0);
        wr(RAG_OFS_CTRL, 32'hffffffff);
        rd_chk(RAG_OFS_CTRL, 32'h7);
        wr(RAG_OFS_CTRL, 32'h0);
    endtask

    // region 6: 256 bytes, no access; region 1: 4 kbytes, full access, cacheable
    task automatic s_regions;
        wr(RAG_OFS_SEL, 32'h3);
        rd_chk(RAG_OFS_SEL, 32'h3);
        wr(RAG_OFS_BASE, 32'h20000016);
        rd_chk(RAG_OFS_SEL, 32'h6);
        rd_chk(RAG_OFS_BASE, 32'h20000006);
        wr(RAG_OFS_ATTR, 32'h0000000f);
        rd_chk(RAG_OFS_ATTR, 32'h0000000f);
        wr(RAG_OFS_SEL, 32'h1);
        wr(RAG_OFS_BASE, 32'h2000000b);
        rd_chk(RAG_OFS_SEL, 32'h1);
        rd_chk(RAG_OFS_BASE, 32'h20000001);
        wr(RAG_OFS_ATTR, 32'h03020017);
        rd_chk(RAG_OFS_ATTR, 32'h03020017);
    endtask

    task automatic s_disabled;
        acc_chk(32'h20000000, K_U, 10'h0c0, 10'h3f0);
        acc_chk(32'he000ed00, K_U, 10'h130, 10'h3f0);
        wr(RAG_OFS_CTRL, 32'h4);
        acc_chk(32'h20000000, K_U, 10'h0c0, 10'h3f0);
    endtask

    task automatic s_enabled;
        wr(RAG_OFS_CTRL, 32'h1);                       // regions set first
        acc_chk(32'h60000000, K_P, 10'h200, 10'h20f);
        acc_chk(32'h00000040, K_U, 10'h000, 10'h200);
        acc_chk(32'he000ed00, K_U, 10'h130, 10'h3f0);
        acc_chk(32'h60000000, K_H, 10'h000, 10'h200);
        wr(RAG_OFS_CTRL, 32'h3);
        acc_chk(32'h60000000, K_H, 10'h200, 10'h200);
    endtask

    task automatic s_privdef;
        wr(RAG_OFS_CTRL, 32'h5);
        acc_chk(32'h60000000, K_P, 10'h0c0, 10'h3ff);
        acc_chk(32'h60000000, K_U, 10'h200, 10'h20f);
        acc_chk(32'h20000010, K_P, 10'h20e, 10'h20f);
        acc_chk(32'h20000400, K_U, 10'h089, 10'h3ff);
        acc_chk(32'h20000400, K_F, 10'h089, 10'h3ff);
    endtask

    // region 2: 1 kbyte device at 0x30000000, user read-only, execute-never, subregion 1 off
    task automatic s_perm;
        wr(RAG_OFS_BASE, 32'h30000012);
        wr(RAG_OFS_ATTR, 32'h12050213);
        rd_chk(RAG_OFS_ATTR, 32'h12050213);
        acc_chk(32'h30000000, K_U, 10'h16a, 10'h3ff);
        acc_chk(32'h30000000, 4'h8, 10'h20a, 10'h20f);
        acc_chk(32'h30000000, K_P | K_F, 10'h20a, 10'h20f);
        acc_chk(32'h30000080, K_U, 10'h200, 10'h20f);
        acc_chk(32'h30000080, K_P, 10'h0c0, 10'h3ff);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, req} = 4'h0;
        {paddr, pwdata, req_addr} = {32'h0, 32'h0, 32'h0};
        req_kind = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_reset_and_info();
        s_regions();
        s_disabled();
        s_enabled();
        s_privdef();
        s_perm();
        report_and_stop();
    end

    // the run needs a few hundred cycles; this limit is far beyond it
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
